// File: hw/siobt_card.sv
// I/O interface card end: own select decode, one data register
`timescale 1ns/1ps
`include "siobt_consts.svh"
module siobt_card #(
  parameter logic [`SIOBT_SEL_W-1:0] MY_CODE = `SIOBT_CODE_SERIAL_DATA
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  siobt_if.card_end bp,
  input wire logic [`SIOBT_WORD_W-1:0] i_read_word,
  output logic [`SIOBT_WORD_W-1:0] o_written_word,
  output logic o_written_pulse,
  output logic o_read_done_pulse,
  output logic o_selected
);
  logic [`SIOBT_SEL_W-1:0] sel_reg;
  logic pulse_d_reg;
  logic hit;
  assign hit = (sel_reg == MY_CODE);
  assign o_selected = hit;
  // Captures newest code on every load strobe; set to 3F at reset
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      sel_reg <= `SIOBT_SEL_RESET;
    end
    else if (!bp.select_code_load_n)
    begin
      sel_reg <= bp.bus[`SIOBT_SEL_W-1:0];
    end
  end
  // Drive only when commanded
  assign bp.card_to_bus = i_read_word;
  assign bp.card_bus_oe = hit && !bp.device_read_strobe_n;
  assign bp.width_select_wide = 1'b0;
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_written_word <= '0;
      o_written_pulse <= 1'b0;
    end
    else
    begin
      o_written_pulse <= 1'b0;
      if (hit && !bp.device_write_strobe_n && bp.slow_transfer_pulse && !pulse_d_reg)
      begin
        o_written_word <= bp.bus;
        o_written_pulse <= 1'b1;
      end
    end
  end
  // Read side effect keyed off the pulse edge, since read strobe may glitch
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      pulse_d_reg <= 1'b0;
      o_read_done_pulse <= 1'b0;
    end
    else
    begin
      pulse_d_reg <= bp.slow_transfer_pulse;
      o_read_done_pulse <= hit && !bp.device_read_strobe_n
        && bp.slow_transfer_pulse && !pulse_d_reg;
    end
  end
endmodule // siobt_card

// File: hw/siobt_consts.svh
// Constants of the slow I/O bus transfer port
`ifndef SIOBT_CONSTS_SVH
`define SIOBT_CONSTS_SVH
`define SIOBT_WORD_W 16
`define SIOBT_SEL_W 6
`define SIOBT_LOW_BITS 3
`define SIOBT_BANKS 8
`define SIOBT_DATA_CYCLES 4
`define SIOBT_PULSE_FIRST 1
`define SIOBT_PULSE_LAST 2
`define SIOBT_CYCLE_NS 150
`define SIOBT_CLK_NS 40
`define SIOBT_SEL_RESET 6'h3F
`define SIOBT_FIFO_DEPTH 4
`define SIOBT_CODE_DISPLAY 6'h00
`define SIOBT_CODE_KBD_STATUS 6'h01
`define SIOBT_CODE_KBD_DATA 6'h02
`define SIOBT_CODE_MOUSE_BTN_RTC 6'h03
`define SIOBT_CODE_SERIAL_DATA 6'h04
`define SIOBT_CODE_SERIAL_STATUS 6'h05
`define SIOBT_CODE_MOUSE_X 6'h06
`define SIOBT_CODE_MOUSE_Y 6'h07
`define SIOBT_CODE_DISK_DATA 6'h08
`define SIOBT_CODE_DISK_STATUS 6'h09
`define SIOBT_CODE_DISK_HI_TRACK 6'h0A
`define SIOBT_CODE_DISK_LO_TRACK 6'h0B
`define SIOBT_CODE_DISK_SECTOR 6'h0C
`endif

// File: hw/siobt_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module siobt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_reg[rd_reg];
  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // siobt_fifo

// File: hw/siobt_if.sv
// Backplane between the data port and an I/O interface card
`timescale 1ns/1ps
`include "siobt_consts.svh"
interface siobt_if;
  logic [`SIOBT_WORD_W-1:0] cpu_to_bus;
  logic cpu_bus_oe;
  logic [`SIOBT_WORD_W-1:0] card_to_bus;
  logic card_bus_oe;
  logic [`SIOBT_WORD_W-1:0] bus;
  logic select_code_load_n;
  logic device_write_strobe_n;
  logic device_read_strobe_n;
  logic slow_transfer_pulse;
  logic [`SIOBT_BANKS-1:0] group_select_n;
  logic [`SIOBT_LOW_BITS-1:0] select_code_low;
  logic width_select_wide;
  // Bus level resolved from the two enables
  assign bus = cpu_bus_oe ? cpu_to_bus : (card_bus_oe ? card_to_bus : '0);
  modport port_end (
    output cpu_to_bus, cpu_bus_oe, select_code_load_n, device_write_strobe_n,
    output device_read_strobe_n, slow_transfer_pulse, group_select_n, select_code_low,
    input bus, width_select_wide
  );
  modport card_end (
    output card_to_bus, card_bus_oe, width_select_wide,
    input bus, select_code_load_n, device_write_strobe_n, device_read_strobe_n,
    input slow_transfer_pulse, group_select_n, select_code_low
  );
endinterface

// File: hw/siobt_pkg.sv
// Types of the slow I/O bus transfer port
package siobt_pkg;
  typedef enum logic [1:0] {SIOBT_OP_READ, SIOBT_OP_WRITE} siobt_op_t;
  typedef enum logic [2:0] {SIOBT_IDLE, SIOBT_SELECT, SIOBT_DATA, SIOBT_DONE} siobt_state_t;
endpackage

// File: hw/siobt_port.sv
// Data port end: sequences select cycle and four data cycles
`timescale 1ns/1ps
`include "siobt_consts.svh"
// Contract
// - Bus carries 16-bit words, one-cycle moves
// - Data phase held four cycles
// - Five cycles; first loads selection code
// - Selected card supplies or accepts data
// - Low load strobe latches bus word
// - Selection plus strobes form per-device command
// - One transfer pulse, longer than cycle
// - Read data taken by cycle clock
// - Read side effects use transfer pulse
// - Code moves in one cycle, strobe low
// - Card captures newest code each strobe
// - Matching card answers four-cycle transfer
// - One low bank select per eight codes
// - Bank selects and low bits on backplane
// - Codes 00 to 07 preassigned devices
// - Serial uses codes 04 and 05
// - Disk uses codes 10 to 17 octal
// - Memory writes 16, reads 16 or 64
// - Card drives width select when granted
// - Display descriptor address by programmed write
// - Narrow cards use single-word transfers
module siobt_port #(
  parameter int DATA_CYCLES = `SIOBT_DATA_CYCLES,
  parameter int FIFO_DEPTH = `SIOBT_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [`SIOBT_SEL_W-1:0] i_req_code,
  input wire logic [`SIOBT_WORD_W-1:0] i_req_data,
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output logic [`SIOBT_WORD_W-1:0] o_rsp_data,
  output logic o_busy,
  siobt_if.port_end bp
);
  localparam int REQ_W = 1 + `SIOBT_SEL_W + `SIOBT_WORD_W;
  localparam int CNT_W = $clog2(DATA_CYCLES + 1);
  siobt_pkg::siobt_state_t state_reg;
  siobt_pkg::siobt_state_t state_next;
  siobt_pkg::siobt_op_t op_reg;
  logic [REQ_W-1:0] q_data;
  logic q_valid;
  logic q_take;
  logic [CNT_W-1:0] cnt_reg;
  logic [`SIOBT_SEL_W-1:0] sel_reg;
  logic [`SIOBT_WORD_W-1:0] wdata_reg;
  logic [`SIOBT_WORD_W-1:0] rdata_reg;
  logic rsp_reg;
  logic last_data;
  logic pulse_next;
  // Requests queue here so the caller can run ahead of slow transfers
  siobt_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_req_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_req_valid),
    .o_in_ready(o_req_ready),
    .i_in_data({i_req_write, i_req_code, i_req_data}),
    .o_out_valid(q_valid),
    .i_out_ready(q_take),
    .o_out_data(q_data)
  );
  // Response stall holds the queue, so back-pressure reaches the caller
  assign q_take = (state_reg == siobt_pkg::SIOBT_IDLE) && !rsp_reg;
  // One decode of the last data cycle aligns state change and read capture
  assign last_data = (state_reg == siobt_pkg::SIOBT_DATA)
    && (cnt_reg == CNT_W'(DATA_CYCLES - 1));
  // Idle spends one cycle per transfer handing over the next request
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      siobt_pkg::SIOBT_IDLE:
        if (q_valid && q_take)
        begin
          state_next = siobt_pkg::SIOBT_SELECT;
        end
      siobt_pkg::SIOBT_SELECT:
        state_next = siobt_pkg::SIOBT_DATA;
      siobt_pkg::SIOBT_DATA:
        if (last_data)
        begin
          state_next = siobt_pkg::SIOBT_IDLE;
        end
      default:
        state_next = siobt_pkg::SIOBT_IDLE;
    endcase
  end
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_reg <= siobt_pkg::SIOBT_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  // Data-cycle counter, cleared outside the data phase
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      cnt_reg <= '0;
    end
    else if (state_reg == siobt_pkg::SIOBT_DATA)
    begin
      cnt_reg <= cnt_reg + 1'b1;
    end
    else
    begin
      cnt_reg <= '0;
    end
  end
  // Request fields held for the whole transfer
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      op_reg <= siobt_pkg::SIOBT_OP_READ;
      sel_reg <= `SIOBT_SEL_RESET;
      wdata_reg <= '0;
    end
    else if (q_valid && q_take)
    begin
      op_reg <= q_data[REQ_W-1] ? siobt_pkg::SIOBT_OP_WRITE : siobt_pkg::SIOBT_OP_READ;
      sel_reg <= q_data[`SIOBT_WORD_W +: `SIOBT_SEL_W];
      wdata_reg <= q_data[`SIOBT_WORD_W-1:0];
    end
  end
  // Select cycle puts code on bus; write data held all four cycles
  assign bp.cpu_to_bus = (state_reg == siobt_pkg::SIOBT_SELECT)
    ? {{(`SIOBT_WORD_W-`SIOBT_SEL_W){1'b0}}, sel_reg} : wdata_reg;
  assign bp.cpu_bus_oe = (state_reg == siobt_pkg::SIOBT_SELECT)
    || (state_reg == siobt_pkg::SIOBT_DATA && op_reg == siobt_pkg::SIOBT_OP_WRITE);
  assign bp.select_code_load_n = !(state_reg == siobt_pkg::SIOBT_SELECT);
  assign bp.device_read_strobe_n = !(state_reg == siobt_pkg::SIOBT_DATA
    && op_reg == siobt_pkg::SIOBT_OP_READ);
  assign bp.device_write_strobe_n = !(state_reg == siobt_pkg::SIOBT_DATA
    && op_reg == siobt_pkg::SIOBT_OP_WRITE);
  // Rises with the first data cycle, falls after the last pulse cycle
  always_comb
  begin
    pulse_next = (state_next == siobt_pkg::SIOBT_DATA)
      && (state_reg == siobt_pkg::SIOBT_SELECT
      || cnt_reg < CNT_W'(`SIOBT_PULSE_LAST - 1));
  end
  // Two-cycle pulse spans 300 ns at 150 ns cycles, one per transfer
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      bp.slow_transfer_pulse <= 1'b0;
    end
    else
    begin
      bp.slow_transfer_pulse <= pulse_next;
    end
  end
  // Decoded selects taken from the latched code, not the live bus
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      bp.group_select_n <= '1;
      bp.select_code_low <= '0;
    end
    else if (state_reg == siobt_pkg::SIOBT_SELECT)
    begin
      bp.select_code_low <= sel_reg[`SIOBT_LOW_BITS-1:0];
      bp.group_select_n <= ~(`SIOBT_BANKS'(1) << sel_reg[`SIOBT_SEL_W-1:`SIOBT_LOW_BITS]);
    end
  end
  // Read word taken on the ordinary clock at the last data cycle
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rdata_reg <= '0;
      rsp_reg <= 1'b0;
    end
    else
    begin
      if (rsp_reg && i_rsp_ready)
      begin
        rsp_reg <= 1'b0;
      end
      if (last_data && op_reg == siobt_pkg::SIOBT_OP_READ)
      begin
        rdata_reg <= bp.bus;
        rsp_reg <= 1'b1;
      end
    end
  end
  // Answer held until taken; the queue stalls meanwhile
  assign o_rsp_valid = rsp_reg;
  assign o_rsp_data = rdata_reg;
  assign o_busy = (state_reg != siobt_pkg::SIOBT_IDLE);
endmodule // siobt_port

// File: testbench/siobt_assertions.sv
// Backplane checks between data port and card
`timescale 1ns/1ps
module siobt_assertions (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic cpu_bus_oe,
  input wire logic card_bus_oe,
  input wire logic [15:0] bus,
  input wire logic select_code_load_n,
  input wire logic device_write_strobe_n,
  input wire logic device_read_strobe_n,
  input wire logic slow_transfer_pulse,
  input wire logic [7:0] group_select_n,
  input wire logic [2:0] select_code_low,
  input wire logic width_select_wide
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Short aliases keep the properties readable
  wire ld_n = select_code_load_n;
  wire wr_n = device_write_strobe_n;
  wire rd_n = device_read_strobe_n;
  wire pls = slow_transfer_pulse;
  AST_LOAD_ONE: assert property (!ld_n |=> ld_n)
    else $error("load strobe too long");
  AST_CODE_DRIVEN: assert property (!ld_n |-> cpu_bus_oe && !card_bus_oe)
    else $error("code not driven");
  AST_FOUR_DATA: assert property (!ld_n |=> (!rd_n || !wr_n) [*4] ##1 (rd_n && wr_n))
    else $error("data phase length");
  AST_ONE_PULSE: assert property ($rose(pls) |-> pls [*2] ##1 !pls [*3])
    else $error("pulse shape");
  AST_PULSE_AFTER: assert property ($rose(pls) |-> !$past(ld_n) && !(rd_n && wr_n))
    else $error("pulse not after load");
  AST_BANK: assert property (!ld_n |=> group_select_n == ~(8'h01 << $past(bus[5:3])))
    else $error("bank select");
  AST_LOW: assert property (!ld_n |=> select_code_low == $past(bus[2:0]))
    else $error("low bits");
  AST_HOLD: assert property (!ld_n ##1 1'b1 |=> $stable(group_select_n) [*3])
    else $error("select moved");
  AST_WR_DRIVE: assert property (!wr_n |-> cpu_bus_oe && !card_bus_oe)
    else $error("write not driven");
  AST_RD_FREE: assert property (!rd_n |-> !cpu_bus_oe && wr_n)
    else $error("read bus held");
  AST_WR_STABLE: assert property (!wr_n && !$past(wr_n) |-> $stable(bus))
    else $error("write data moved");
  AST_NARROW: assert property (!width_select_wide)
    else $error("wide read asked");
  cover property ($fell(rd_n));
  cover property ($fell(wr_n));
  cover property ($rose(pls));
endmodule // siobt_assertions

// File: testbench/tb_top.sv
// Bench: data port and card on one backplane
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [5:0] req_code = 6'h00;
  logic [15:0] req_data = 16'h0000;
  logic rsp_ready = 1'b1;
  logic req_ready, rsp_valid, written_pulse, read_done, selected;
  logic [15:0] rsp_data, written_word;
  logic busy;
  int fails = 0;
  int comparisons = 0;
  int pulses = 0;
  int writes = 0;
  int reads = 0;
  int n;
  siobt_if bp_if ();
  siobt_port siobt_port_i (.i_clock(clock), .i_sys_rst(sys_rst), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_write(req_write), .i_req_code(req_code),
    .i_req_data(req_data), .o_rsp_valid(rsp_valid), .i_rsp_ready(rsp_ready),
    .o_rsp_data(rsp_data), .o_busy(busy), .bp(bp_if.port_end));
  siobt_card #(.MY_CODE(6'h04)) siobt_card_i (.i_clock(clock), .i_sys_rst(sys_rst),
    .bp(bp_if.card_end), .i_read_word(16'h3C5A), .o_written_word(written_word),
    .o_written_pulse(written_pulse), .o_read_done_pulse(read_done), .o_selected(selected));
  siobt_assertions siobt_assertions_i (.i_clock(clock), .i_sys_rst(sys_rst),
    .cpu_bus_oe(bp_if.cpu_bus_oe), .card_bus_oe(bp_if.card_bus_oe), .bus(bp_if.bus),
    .select_code_load_n(bp_if.select_code_load_n),
    .device_write_strobe_n(bp_if.device_write_strobe_n),
    .device_read_strobe_n(bp_if.device_read_strobe_n),
    .slow_transfer_pulse(bp_if.slow_transfer_pulse),
    .group_select_n(bp_if.group_select_n), .select_code_low(bp_if.select_code_low),
    .width_select_wide(bp_if.width_select_wide));
  initial
    forever #20 clock = ~clock;
  always @(posedge bp_if.slow_transfer_pulse)
    pulses++;
  always @(posedge clock)
  begin
    if (written_pulse)
      writes++;
    if (read_done)
      reads++;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic push(input logic wr, input logic [5:0] code, input logic [15:0] data);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_code <= code;
    req_data <= data;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (req_ready !== 1'b1 && n < 50);
    check("req_ready", {15'h0000, req_ready}, 16'h0001);
    req_valid <= 1'b0;
  endtask
  // Takes the answer at the edge where valid meets ready; n counts edges since the call
  task automatic wait_rsp(input logic [15:0] exp);
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1) && n < 100);
    check("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
    check("rsp_data", rsp_data, exp);
  endtask
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    #1 check("selected", {15'h0000, selected}, 16'h0000);
    push(1'b1, 6'h04, 16'hA5C3);
    repeat (2) @(posedge clock);
    check("busy", {15'h0000, busy}, 16'h0001);
    repeat (6) @(posedge clock);
    #1 check("written", written_word, 16'hA5C3);
    check("writes", 16'(writes), 16'h0001);
    check("pulses", 16'(pulses), 16'h0001);
    push(1'b0, 6'h04, 16'h0000);
    wait_rsp(16'h3C5A);
    check("latency", 16'(n), 16'h0007);
    check("reads", 16'(reads), 16'h0001);
    // Every code of the map, octal 00 to 17
    for (int k = 0; k < 16; k++)
    begin
      push(1'b0, 6'(k), 16'h0000);
      wait_rsp((k == 4) ? 16'h3C5A : 16'h0000);
      check("bank", {8'h00, bp_if.group_select_n}, {8'h00, ~(8'h01 << k[5:3])});
      check("low", {13'h0000, bp_if.select_code_low}, {13'h0000, k[2:0]});
    end
    push(1'b1, 6'h05, 16'h1111);
    repeat (8) @(posedge clock);
    #1 check("written", written_word, 16'hA5C3);
    check("selected", {15'h0000, selected}, 16'h0000);
    // Pending answer blocks the port, so the FIFO fills and refuses
    @(posedge clock);
    rsp_ready <= 1'b0;
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_code <= 6'h04;
    n = 0;
    repeat (24)
    begin
      @(posedge clock);
      if (req_ready === 1'b1)
        n++;
    end
    req_valid <= 1'b0;
    rsp_ready <= 1'b1;
    check("accepted", 16'(n), 16'h0005);
    for (int k = 0; k < 5; k++)
      wait_rsp(16'h3C5A);
    check("reads", 16'(reads), 16'h0007);
    check("pulses", 16'(pulses), 16'h0018);
    check("busy", {15'h0000, busy}, 16'h0000);
    close_out();
  end
  initial
  begin
    repeat (4000) @(posedge clock);
    fails++;
    close_out();
  end
endmodule // tb_top
